// *** design/stc_top.sv ***
// Stencil test control: APB held state words plus a per-pixel
// read-modify-write engine towards the stencil buffer storage.
// Assumes storage answers a read in a fixed single cycle and that pixel
// inputs are synchronous to pclk.
`include "stc_params.svh"

// Function
// - Depth-pass op applied on stencil and depth pass
// - Writes only while stencil write enable set
// - Test enable cleared blocks every stencil write
// - Double-sided switch enables back-face processing
// - Back-facing when winding opposes front winding
// - Culling independent of double-sided setting
// - Back faces use all other state unchanged
// - Back-face compare code decoded, eight functions
// - Stencil operation codes decoded, eight operations
// - Reference and stored value ANDed with mask
// - Only write-mask bits of stored value change
// - Read skipped when no op, compare or partial write mask needs it
module stc_top #(
    parameter int W = 8,
    parameter int AW = 16
) (
    // Clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          clk_en,
    // APB slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    // Pixel request
    input  wire logic          pix_valid,
    input  wire logic [AW-1:0] pix_addr,
    input  wire logic          pix_ccw,
    input  wire logic          pix_depth_pass,
    output logic               pix_ready,
    // Pixel result
    output logic               res_valid,
    output logic               res_stencil_pass,
    output logic               res_culled,
    // Stencil buffer storage
    output logic               sb_rd_en,
    output logic [AW-1:0]      sb_addr,
    input  wire logic [W-1:0]  sb_rd_data,
    output logic               sb_wr_en,
    output logic [W-1:0]       sb_wr_data
);
    if (W != 8) begin : g_w_check
        $error("stc_top: W must be 8");
    end
    if (AW < 1) begin : g_aw_check
        $error("stc_top: AW must be positive");
    end

    logic [31:0] state0_reg;
    logic [31:0] state1_reg;
    logic [31:0] state2_reg;
    logic [31:0] ctrl_reg;
    logic [31:0] count_reg;
    stc_pkg::stc_state_t st_reg;
    stc_pkg::stc_state_t st_next;

    // APB access phase completes in its first cycle
    logic acc;
    logic wr_acc;
    assign acc = psel & penable & clk_en;
    assign wr_acc = acc & pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state0_reg <= `STC_STATE_RESET;
            state1_reg <= `STC_STATE_RESET;
            state2_reg <= `STC_STATE_RESET;
            ctrl_reg   <= `STC_CTRL_RESET;
        end else if (wr_acc) begin
            unique case (paddr)
                `STC_OFF_STATE0: state0_reg <= pwdata & `STC_W0_RW_MASK;
                `STC_OFF_STATE1: state1_reg <= pwdata;
                `STC_OFF_STATE2: state2_reg <= pwdata & `STC_W2_RW_MASK;
                `STC_OFF_CTRL:   ctrl_reg   <= {30'h0000_0000, pwdata[1:0]};
                default: ;
            endcase
        end
    end

    logic addr_ok;
    always_comb begin
        unique case (paddr)
            `STC_OFF_STATE0, `STC_OFF_STATE1, `STC_OFF_STATE2,
            `STC_OFF_CTRL, `STC_OFF_STATUS, `STC_OFF_COUNT: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_ok;
            if (psel & ~penable & ~pwrite) begin
                unique case (paddr)
                    `STC_OFF_STATE0: prdata <= state0_reg;
                    `STC_OFF_STATE1: prdata <= state1_reg;
                    `STC_OFF_STATE2: prdata <= state2_reg;
                    `STC_OFF_CTRL:   prdata <= ctrl_reg;
                    `STC_OFF_STATUS: prdata <= {30'h0000_0000, st_reg};
                    `STC_OFF_COUNT:  prdata <= count_reg;
                    default:         prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Field views
    logic test_en;
    logic write_en;
    logic double_en;
    logic front_cw;
    logic cull_back;
    assign test_en   = state0_reg[`STC_W0_TEST_EN];
    assign write_en  = state0_reg[`STC_W0_WRITE_EN];
    assign double_en = state0_reg[`STC_W0_DOUBLE_EN];
    assign front_cw  = ctrl_reg[0];
    assign cull_back = ctrl_reg[1];

    // Captured pixel
    logic          back_reg;
    logic          zpass_reg;
    logic          use_back;

    // Winding opposite to the front winding marks a back face
    logic is_back;
    assign is_back = pix_ccw == front_cw;
    assign use_back = back_reg & double_en;

    // Face field selection; all other state stays shared
    logic [2:0]   f_func;
    logic [2:0]   f_fail;
    logic [2:0]   f_zfail;
    logic [2:0]   f_zpass;
    logic [W-1:0] f_ref;
    logic [W-1:0] f_tmask;
    logic [W-1:0] f_wmask;
    always_comb begin
        if (use_back) begin
            f_func  = state0_reg[`STC_W0_BFUNC_HI:`STC_W0_BFUNC_LO];
            f_fail  = state0_reg[`STC_W0_BFAIL_HI:`STC_W0_BFAIL_LO];
            f_zfail = state0_reg[`STC_W0_BZFAIL_HI:`STC_W0_BZFAIL_LO];
            f_zpass = state0_reg[`STC_W0_BZPASS_HI:`STC_W0_BZPASS_LO];
            f_ref   = state1_reg[`STC_W1_BREF_HI:`STC_W1_BREF_LO];
            f_tmask = state2_reg[`STC_W2_BTMASK_HI:`STC_W2_BTMASK_LO];
            f_wmask = state2_reg[`STC_W2_BWMASK_HI:`STC_W2_BWMASK_LO];
        end else begin
            f_func  = state0_reg[`STC_W0_FUNC_HI:`STC_W0_FUNC_LO];
            f_fail  = state0_reg[`STC_W0_FAIL_HI:`STC_W0_FAIL_LO];
            f_zfail = state0_reg[`STC_W0_ZFAIL_HI:`STC_W0_ZFAIL_LO];
            f_zpass = state0_reg[`STC_W0_ZPASS_HI:`STC_W0_ZPASS_LO];
            f_ref   = state1_reg[`STC_W1_REF_HI:`STC_W1_REF_LO];
            f_tmask = state1_reg[`STC_W1_TMASK_HI:`STC_W1_TMASK_LO];
            f_wmask = state1_reg[`STC_W1_WMASK_HI:`STC_W1_WMASK_LO];
        end
    end

    // A read is needed only when an op, the compare or a partial write mask uses the stored value
    function automatic logic op_reads(input logic [2:0] o);
        op_reads = o > 3'h2;
    endfunction

    // Need per face; a partial write mask needs the bits it keeps
    logic need_front;
    logic need_back;
    logic need_read;
    logic need_take;
    assign need_front = op_reads(state0_reg[`STC_W0_FAIL_HI:`STC_W0_FAIL_LO])
                      | op_reads(state0_reg[`STC_W0_ZFAIL_HI:`STC_W0_ZFAIL_LO])
                      | op_reads(state0_reg[`STC_W0_ZPASS_HI:`STC_W0_ZPASS_LO])
                      | (state0_reg[`STC_W0_FUNC_HI:`STC_W0_FUNC_LO] > 3'h1)
                      | ~&state1_reg[`STC_W1_WMASK_HI:`STC_W1_WMASK_LO];
    assign need_back  = op_reads(state0_reg[`STC_W0_BFAIL_HI:`STC_W0_BFAIL_LO])
                      | op_reads(state0_reg[`STC_W0_BZFAIL_HI:`STC_W0_BZFAIL_LO])
                      | op_reads(state0_reg[`STC_W0_BZPASS_HI:`STC_W0_BZPASS_LO])
                      | (state0_reg[`STC_W0_BFUNC_HI:`STC_W0_BFUNC_LO] > 3'h1)
                      | ~&state2_reg[`STC_W2_BWMASK_HI:`STC_W2_BWMASK_LO];
    assign need_read = use_back ? need_back : need_front;
    // The read is issued before the pixel's face is registered
    assign need_take = (is_back & double_en) ? need_back : need_front;

    logic [W-1:0] stored;
    logic         pass;
    logic [2:0]   op_sel;
    logic [W-1:0] op_val;
    assign stored = need_read ? sb_rd_data : '0;

    stc_alu #(.W(W)) u_alu (
        .func      (f_func),
        .op_sel    (op_sel),
        .ref_val   (f_ref),
        .test_mask (f_tmask),
        .stored    (stored),
        .pass      (pass),
        .new_val   (op_val)
    );

    always_comb begin
        if (!pass)
            op_sel = f_fail;
        else if (zpass_reg)
            op_sel = f_zpass;
        else
            op_sel = f_zfail;
    end

    // Culling looks only at winding and the cull control bit
    logic culled;
    assign culled = is_back & cull_back;

    logic take;
    assign take = pix_valid & pix_ready & clk_en;

    always_comb begin
        st_next = st_reg;
        unique case (st_reg)
            stc_pkg::st_idle:  if (take && !culled) st_next = stc_pkg::st_read;
            stc_pkg::st_read:  st_next = stc_pkg::st_write;
            stc_pkg::st_write: st_next = stc_pkg::st_idle;
            default:           st_next = stc_pkg::st_idle;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            st_reg <= stc_pkg::st_idle;
        else if (clk_en)
            st_reg <= st_next;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            back_reg  <= 1'b0;
            zpass_reg <= 1'b0;
            pix_ready <= 1'b0;
        end else if (clk_en) begin
            pix_ready <= (st_next == stc_pkg::st_idle);
            if (take) begin
                back_reg  <= is_back;
                zpass_reg <= pix_depth_pass;
            end
        end
    end

    // Storage port: read in st_read, write-back two cycles after the read
    logic do_write;
    assign do_write = test_en & write_en;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sb_rd_en   <= 1'b0;
            sb_addr    <= '0;
            sb_wr_en   <= 1'b0;
            sb_wr_data <= '0;
        end else if (clk_en) begin
            sb_rd_en <= (st_next == stc_pkg::st_read) & need_take;
            sb_wr_en <= 1'b0;
            if (take)
                sb_addr <= pix_addr;
            if (st_reg == stc_pkg::st_write) begin
                // Keep changes nothing, so a skipped read cannot zero the entry
                sb_wr_en   <= do_write & (op_sel != stc_pkg::sop_keep);
                sb_wr_data <= (op_val & f_wmask) | (stored & ~f_wmask);
            end
        end
    end

    // Pixel verdict and pass counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_valid        <= 1'b0;
            res_stencil_pass <= 1'b0;
            res_culled       <= 1'b0;
            count_reg        <= 32'h0000_0000;
        end else if (clk_en) begin
            res_valid  <= 1'b0;
            res_culled <= 1'b0;
            if (take && culled) begin
                res_valid        <= 1'b1;
                res_culled       <= 1'b1;
                res_stencil_pass <= 1'b0;
            end else if (st_reg == stc_pkg::st_write) begin
                res_valid        <= 1'b1;
                res_stencil_pass <= pass | ~test_en;
                if (pass | ~test_en)
                    count_reg <= count_reg + 32'h0000_0001;
            end
        end
    end
endmodule // stc_top

// *** pkg/stc_params.svh ***
// Constants of the stencil test control block: state word field positions,
// APB register byte offsets and reset values.
// Assumes one pipeline clock shared with the APB slave.
`ifndef STC_PARAMS_SVH
`define STC_PARAMS_SVH

// State word 0 fields
`define STC_W0_TEST_EN       31
`define STC_W0_FUNC_HI       30
`define STC_W0_FUNC_LO       28
`define STC_W0_FAIL_HI       27
`define STC_W0_FAIL_LO       25
`define STC_W0_ZFAIL_HI      24
`define STC_W0_ZFAIL_LO      22
`define STC_W0_ZPASS_HI      21
`define STC_W0_ZPASS_LO      19
`define STC_W0_WRITE_EN      18
`define STC_W0_DOUBLE_EN     15
`define STC_W0_BFUNC_HI      14
`define STC_W0_BFUNC_LO      12
`define STC_W0_BFAIL_HI      11
`define STC_W0_BFAIL_LO      9
`define STC_W0_BZFAIL_HI     8
`define STC_W0_BZFAIL_LO     6
`define STC_W0_BZPASS_HI     5
`define STC_W0_BZPASS_LO     3
// State word 1 fields
`define STC_W1_REF_HI        31
`define STC_W1_REF_LO        24
`define STC_W1_TMASK_HI      23
`define STC_W1_TMASK_LO      16
`define STC_W1_WMASK_HI      15
`define STC_W1_WMASK_LO      8
`define STC_W1_BREF_HI       7
`define STC_W1_BREF_LO       0
// State word 2 fields
`define STC_W2_BTMASK_HI     31
`define STC_W2_BTMASK_LO     24
`define STC_W2_BWMASK_HI     23
`define STC_W2_BWMASK_LO     16

// APB byte offsets
`define STC_OFF_STATE0       12'h000
`define STC_OFF_STATE1       12'h004
`define STC_OFF_STATE2       12'h008
`define STC_OFF_CTRL         12'h00C
`define STC_OFF_STATUS       12'h010
`define STC_OFF_COUNT        12'h014

// Reserved bits 17:16 and 2:0 of word 0 read as zero
`define STC_W0_RW_MASK       32'hFFFC_FFF8
`define STC_W2_RW_MASK       32'hFFFF_0000
`define STC_STATE_RESET      32'h0000_0000
`define STC_CTRL_RESET       32'h0000_0000

`endif

// *** pkg/stc_pkg.sv ***
// Types of the stencil test control block.
// Assumes nothing of its surroundings.
package stc_pkg;

    typedef enum logic [2:0] {
        cmp_always           = 3'h0,
        cmp_never            = 3'h1,
        cmp_less             = 3'h2,
        cmp_equal            = 3'h3,
        cmp_less_or_equal    = 3'h4,
        cmp_greater          = 3'h5,
        cmp_not_equal        = 3'h6,
        cmp_greater_or_equal = 3'h7
    } stc_cmp_t;

    typedef enum logic [2:0] {
        sop_keep                 = 3'h0,
        sop_zero                 = 3'h1,
        sop_replace              = 3'h2,
        sop_increment_saturating = 3'h3,
        sop_decrement_saturating = 3'h4,
        sop_increment_wrapping   = 3'h5,
        sop_decrement_wrapping   = 3'h6,
        sop_invert               = 3'h7
    } stc_sop_t;

    typedef enum logic [1:0] {
        st_idle  = 2'b00,
        st_read  = 2'b01,
        st_write = 2'b10
    } stc_state_t;

endpackage : stc_pkg

// *** design/stc_alu.sv ***
// Stencil compare and operation unit, purely combinational.
// Assumes the caller has already picked the face's fields.
module stc_alu #(
    parameter int W = 8
) (
    // Face settings
    input  wire logic [2:0]   func,
    input  wire logic [2:0]   op_sel,
    input  wire logic [W-1:0] ref_val,
    input  wire logic [W-1:0] test_mask,
    // Stored value
    input  wire logic [W-1:0] stored,
    // Results
    output logic              pass,
    output logic [W-1:0]      new_val
);
    logic [W-1:0] lhs;
    logic [W-1:0] rhs;

    assign lhs = ref_val & test_mask;
    assign rhs = stored & test_mask;

    always_comb begin
        unique case (stc_pkg::stc_cmp_t'(func))
            stc_pkg::cmp_always:           pass = 1'b1;
            stc_pkg::cmp_never:            pass = 1'b0;
            stc_pkg::cmp_less:             pass = lhs <  rhs;
            stc_pkg::cmp_equal:            pass = lhs == rhs;
            stc_pkg::cmp_less_or_equal:    pass = lhs <= rhs;
            stc_pkg::cmp_greater:          pass = lhs >  rhs;
            stc_pkg::cmp_not_equal:        pass = lhs != rhs;
            stc_pkg::cmp_greater_or_equal: pass = lhs >= rhs;
        endcase
    end

    always_comb begin
        unique case (stc_pkg::stc_sop_t'(op_sel))
            stc_pkg::sop_keep:    new_val = stored;
            stc_pkg::sop_zero:    new_val = '0;
            stc_pkg::sop_replace: new_val = ref_val;
            stc_pkg::sop_increment_saturating:
                new_val = (&stored) ? stored : W'(stored + 1'b1);
            stc_pkg::sop_decrement_saturating:
                new_val = (stored == '0) ? stored : W'(stored - 1'b1);
            stc_pkg::sop_increment_wrapping: new_val = W'(stored + 1'b1);
            stc_pkg::sop_decrement_wrapping: new_val = W'(stored - 1'b1);
            stc_pkg::sop_invert:             new_val = ~stored;
        endcase
    end
endmodule // stc_alu

// *** tb/stc_sb_model.sv ***
// Behavioural stencil buffer storage facing the stencil engine.
// Assumes one read pulse per pixel and answers it in the next cycle.
module stc_sb_model #(
    parameter int W  = 8,
    parameter int AW = 16
) (
    // Clock
    input  wire logic          pclk,
    // Storage port
    input  wire logic          sb_rd_en,
    input  wire logic [AW-1:0] sb_addr,
    output logic [W-1:0]       sb_rd_data,
    input  wire logic          sb_wr_en,
    input  wire logic [W-1:0]  sb_wr_data
);
    timeunit 1ns;
    timeprecision 1ns;
    // Storage is present, so software may set the write enable
    logic [W-1:0] mem [256];
    initial sb_rd_data = '0;
    // Outside the answer cycle the data toggles, so stale data never looks valid
    always @(posedge pclk) begin
        if (sb_rd_en) sb_rd_data <= mem[sb_addr[7:0]];
        else sb_rd_data <= ~sb_rd_data;
        if (sb_wr_en) mem[sb_addr[7:0]] <= sb_wr_data;
    end
endmodule // stc_sb_model

// *** tb/stc_top_monitor.sv ***
// Checker on the ports of the stencil test control top.
// Assumes clk_en is held high and pclk is the only clock.
`include "stc_params.svh"
module stc_top_monitor #(
    parameter int W  = 8,
    parameter int AW = 16
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // APB
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    input  wire logic         pready,
    input  wire logic         pslverr,
    // Pixel side
    input  wire logic         pix_valid,
    input  wire logic         pix_ready,
    input  wire logic         res_valid,
    input  wire logic         res_culled,
    // Storage
    input  wire logic         sb_rd_en,
    input  wire logic [W-1:0] sb_rd_data,
    input  wire logic         sb_wr_en,
    input  wire logic [W-1:0] sb_wr_data
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [31:0]  w0_reg, w1_reg, w2_reg, ctl_reg;
    logic [W-1:0] old_reg;
    logic         rd_pend_reg;
    wire logic wr_acc = psel && penable && pready && pwrite && !pslverr;
    wire logic ops_small = (w0_reg[27:25] < 3'h3) && (w0_reg[24:22] < 3'h3)
        && (w0_reg[21:19] < 3'h3) && (w0_reg[11:9] < 3'h3)
        && (w0_reg[8:6] < 3'h3) && (w0_reg[5:3] < 3'h3)
        && (w0_reg[30:28] < 3'h2) && (w0_reg[14:12] < 3'h2)
        && (&w1_reg[15:8]) && (&w2_reg[23:16]);
    wire logic [W-1:0] fixed_bits = ~(w1_reg[15:8] | w2_reg[23:16]);
    // Shadow of the state words as written over APB
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            w0_reg <= '0;
            w1_reg <= '0;
            w2_reg <= '0;
            ctl_reg <= '0;
        end else if (wr_acc) begin
            if (paddr == `STC_OFF_STATE0) w0_reg <= pwdata;
            if (paddr == `STC_OFF_STATE1) w1_reg <= pwdata;
            if (paddr == `STC_OFF_STATE2) w2_reg <= pwdata;
            if (paddr == `STC_OFF_CTRL) ctl_reg <= pwdata;
        end
    end
    // Stored value the engine sees; zero when the read is skipped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            old_reg <= '0;
            rd_pend_reg <= 1'b0;
        end else begin
            rd_pend_reg <= sb_rd_en;
            if (rd_pend_reg) old_reg <= sb_rd_data;
            else if (pix_valid && pix_ready) old_reg <= '0;
        end
    end
    sequence s_take; pix_valid && pix_ready; endsequence
    sequence s_cull_ans; res_valid && res_culled; endsequence
    sequence s_late_ans; ##2 (res_valid && !res_culled); endsequence
    apb_no_wait_a: assert property (psel && !penable |=> pready)
        else $error("pready missing in access phase");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    unmapped_err_a: assert property (psel && !penable && paddr > `STC_OFF_COUNT |=> pready && pslverr)
        else $error("unmapped access not refused");
    take_answer_a: assert property (s_take |=> s_cull_ans or s_late_ans)
        else $error("pixel answer late");
    rd_answer_a: assert property (sb_rd_en |-> s_late_ans)
        else $error("read not followed by result");
    wr_gate_a: assert property (sb_wr_en |-> w0_reg[`STC_W0_TEST_EN] && w0_reg[`STC_W0_WRITE_EN])
        else $error("stencil write while disabled");
    wr_mask_a: assert property (sb_wr_en |-> ((sb_wr_data ^ old_reg) & fixed_bits) == '0)
        else $error("masked stencil bit changed");
    read_skip_a: assert property (sb_rd_en |-> !ops_small)
        else $error("needless stencil read");
    cull_only_a: assert property (res_culled |-> res_valid && !sb_wr_en && ctl_reg[1])
        else $error("unexpected cull");
endmodule // stc_top_monitor

bind stc_top stc_top_monitor #(.W(W), .AW(AW)) mon (.*);

// *** tb/stc_top_tb_top.sv ***
// Self-checking bench for the stencil test control top.
// Assumes the storage model and the monitor are compiled alongside.
`include "stc_params.svh"
module stc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [31:0] w0;
        logic [2:0]  f;
        logic [7:0]  init;
        logic [7:0]  val;
    } stc_row_t;
    localparam int NR = 21;
    logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pix_valid = 1'b0, pix_ccw = 1'b0, pix_depth_pass = 1'b0, pix_ready;
    logic [15:0] pix_addr = 16'h0000, sb_addr;
    logic res_valid, res_stencil_pass, res_culled, sb_rd_en, sb_wr_en, er, ps, cu;
    logic [7:0] sb_rd_data, sb_wr_data;
    int err_count = 0, tests_run = 0;
    // Flags are {ccw, depth pass, expected stencil pass}
    stc_row_t rows [NR] = '{
        '{32'h8004_0000, 3'h7, 8'h33, 8'h33}, '{32'h800C_0000, 3'h7, 8'h33, 8'h00},
        '{32'h8014_0000, 3'h7, 8'h33, 8'h10}, '{32'h801C_0000, 3'h7, 8'hFF, 8'hFF},
        '{32'h8024_0000, 3'h7, 8'h00, 8'h00}, '{32'h802C_0000, 3'h7, 8'hFF, 8'h00},
        '{32'h8034_0000, 3'h7, 8'h00, 8'hFF}, '{32'h803C_0000, 3'h7, 8'h33, 8'hCC},
        '{32'h8004_8038, 3'h3, 8'h30, 8'hCF}, '{32'h8004_9038, 3'h2, 8'h30, 8'h30},
        '{32'h8004_A038, 3'h3, 8'h30, 8'hCF}, '{32'h8004_B038, 3'h2, 8'h30, 8'h30},
        '{32'h8004_C038, 3'h3, 8'h30, 8'hCF}, '{32'h8004_D038, 3'h2, 8'h30, 8'h30},
        '{32'h8004_E038, 3'h3, 8'h30, 8'hCF}, '{32'h8004_F038, 3'h2, 8'h30, 8'h30},
        '{32'h800C_1038, 3'h3, 8'h30, 8'h00}, '{32'h800C_9038, 3'h7, 8'h30, 8'h00},
        '{32'h8034_0000, 3'h5, 8'h00, 8'h00}, '{32'h8038_0000, 3'h7, 8'h33, 8'h33},
        '{32'h003C_0000, 3'h7, 8'h33, 8'h33}};
    always #10 pclk = ~pclk;
    stc_top #(.W(8), .AW(16)) dut (.*);
    stc_sb_model #(.W(8), .AW(16)) mdl (.*);
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pix(input logic [15:0] a, input logic c, input logic d);
        @(posedge pclk);
        pix_valid <= 1'b1;
        pix_addr <= a;
        pix_ccw <= c;
        pix_depth_pass <= d;
        do begin
            @(posedge pclk);
        end while (pix_ready !== 1'b1);
        pix_valid <= 1'b0;
        do begin
            @(posedge pclk);
        end while (res_valid !== 1'b1);
        ps = res_stencil_pass;
        cu = res_culled;
        #1;
    endtask
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge pclk);
        err_count++;
        $display("Watchdog expired");
        wrap_up();
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 24; a += 4) begin
            apb(1'b0, a[11:0], 32'h0000_0000);
            chk({er, rd}, 36'h0_0000_0000);
        end
        $display("Reset values done");
        apb(1'b1, `STC_OFF_STATE0, 32'hFFFF_FFFF);
        apb(1'b0, `STC_OFF_STATE0, 32'h0000_0000);
        chk(rd, `STC_W0_RW_MASK);
        apb(1'b1, `STC_OFF_STATE2, 32'hFFFF_FFFF);
        apb(1'b0, `STC_OFF_STATE2, 32'h0000_0000);
        chk(rd, `STC_W2_RW_MASK);
        apb(1'b1, 12'h018, 32'hFFFF_FFFF);
        chk(er, 36'h0_0000_0001);
        apb(1'b0, 12'h018, 32'h0000_0000);
        chk({er, rd}, 36'h1_0000_0000);
        $display("Register access done");
        apb(1'b1, `STC_OFF_STATE1, 32'h10FF_FF20);
        apb(1'b1, `STC_OFF_STATE2, 32'hFFFF_0000);
        apb(1'b1, `STC_OFF_CTRL, 32'h0000_0000);
        for (int i = 0; i < NR; i++) begin
            apb(1'b1, `STC_OFF_STATE0, rows[i].w0);
            mdl.mem[i] = rows[i].init;
            pix(i[15:0], rows[i].f[2], rows[i].f[1]);
            chk(ps, rows[i].f[0]);
            chk(mdl.mem[i], rows[i].val);
            $display("Row %0d done", i);
        end
        apb(1'b1, `STC_OFF_CTRL, 32'h0000_0001);
        apb(1'b1, `STC_OFF_STATE1, 32'h1FF0_0F20);
        apb(1'b1, `STC_OFF_STATE2, 32'hFF0F_0000);
        apb(1'b1, `STC_OFF_STATE0, 32'hB03C_9000);
        mdl.mem[40] = 8'h13;
        pix(16'h0028, 1'b0, 1'b1);
        chk(ps, 36'h0_0000_0001);
        chk(mdl.mem[40], 36'h0_0000_001C);
        $display("Mask test done");
        apb(1'b1, `STC_OFF_CTRL, 32'h0000_0002);
        mdl.mem[50] = 8'h55;
        for (int d = 0; d < 2; d++) begin
            apb(1'b1, `STC_OFF_STATE0, 32'h803C_0000 | (d << 15));
            pix(16'h0032, 1'b0, 1'b1);
            chk({cu, mdl.mem[50]}, 36'h0_0000_0155);
        end
        pix(16'h0032, 1'b1, 1'b1);
        chk({cu, mdl.mem[50]}, 36'h0_0000_005A);
        $display("Cull test done");
        // 19 pixels passed or ran with the test off; culled ones do not count
        apb(1'b0, `STC_OFF_COUNT, 32'h0000_0000);
        chk(rd, 36'h0_0000_0013);
        $display("Count test done");
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        chk({pix_ready, res_valid, sb_rd_en, sb_wr_en, pready}, 36'h0_0000_0000);
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `STC_OFF_STATE0, 32'h0000_0000);
        chk(rd, `STC_STATE_RESET);
        apb(1'b0, `STC_OFF_COUNT, 32'h0000_0000);
        chk({er, rd}, 36'h0_0000_0000);
        $display("Mid-run reset done");
        wrap_up();
    end
endmodule // stc_top_tb_top
